// ==== hdl/ext_bus_device.sv ====
`timescale 1ns/1ps
module ext_bus_device (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Configuration
  input  wire logic [1:0]  proc_mode,
  input  wire logic [23:0] area_first [4],
  input  wire logic [23:0] area_last [4],
  input  wire logic [3:1]  area_narrow,
  // Request from the core
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [23:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic [1:0]  req_byte_en,
  output logic             req_ready,
  // Answer to the core
  output logic             resp_valid,
  output logic             resp_internal,
  output logic [15:0]      resp_rdata,
  output logic             bus_held,
  // Pins
  ext_bus_if.device        pins
);

  ext_bus_pkg::bus_state_t state;
  ext_bus_pkg::bus_state_t next_state;

  logic        strap_narrow;
  logic        is_write;
  logic        narrow;
  logic        phase;
  logic        second;
  logic [23:0] base_addr;
  logic [15:0] wdata;
  logic [1:0]  byte_en;
  logic [3:0]  sel_hit;

  // Address decode of the incoming request
  wire ext_mode = (proc_mode == ext_bus_pkg::MODE_MEM_EXPAND) ||
                  (proc_mode == ext_bus_pkg::MODE_MICRO);
  wire in_rom = (req_addr >= ext_bus_pkg::INT_ROM_START) &&
                (req_addr < ext_bus_pkg::INT_ROM_END);
  wire req_ext = ext_mode && (req_addr >= ext_bus_pkg::INT_RAM_END) &&
                 !(in_rom && proc_mode == ext_bus_pkg::MODE_MEM_EXPAND);
  wire hold_asked = !pins.hold_req_n;
  wire in_idle = (state == ext_bus_pkg::ST_IDLE);
  wire in_hold = (state == ext_bus_pkg::ST_HOLD);
  // Internal requests are served in idle and hold alike; req_ready still
  // high means the request on the inputs was taken at the last edge
  wire take_int = req_valid && !req_ready && !req_ext &&
                  (in_idle || in_hold);
  wire take_ext = req_valid && req_ext && in_idle && !hold_asked;
  wire take = take_int || take_ext;

  // Chip select decode, one comparator pair per area
  function automatic logic [3:0] area_hits(input logic [23:0] a);
    logic [3:0] h;
    h = 4'h0;
    for (int i = 0; i < 4; i++)
      h[i] = (a >= area_first[i]) && (a <= area_last[i]);
    return h;
  endfunction

  wire [3:0] req_hits = area_hits(req_addr);
  // Only areas one to three can be narrowed on a wide bus
  wire req_narrow = (strap_narrow == ext_bus_pkg::STRAP_NARROW_8) ||
                    (|(req_hits[3:1] & area_narrow));
  wire both_bytes = &req_byte_en;
  wire first_phase = !req_byte_en[0];

  // Per-beat pin values
  // Latch pulse address and selects: a new request is not registered yet,
  // and a second narrow beat always targets the odd byte
  wire [23:0] first_addr = req_narrow ? {req_addr[23:1], first_phase}
                                      : req_addr;
  wire [23:0] latch_addr = take_ext ? first_addr
                                    : {base_addr[23:1], 1'h1};
  wire [3:0]  latch_sel = take_ext ? req_hits : sel_hit;
  wire [7:0]  beat_byte = phase ? wdata[15:8] : wdata[7:0];
  wire [15:0] beat_wdata = narrow ? {8'hFF, beat_byte} : wdata;
  wire beat_low_wr = narrow ? 1'h1 : byte_en[0];
  wire beat_high_wr = narrow ? 1'h0 : byte_en[1];
  wire beat_done = (state == ext_bus_pkg::ST_STROBE) && pins.ready;
  wire more_beats = narrow && second && !phase;

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      ext_bus_pkg::ST_IDLE:
        if (hold_asked)
          next_state = ext_bus_pkg::ST_HOLD;
        else if (take_ext)
          next_state = ext_bus_pkg::ST_LATCH;
      ext_bus_pkg::ST_LATCH:
        next_state = ext_bus_pkg::ST_STROBE;
      ext_bus_pkg::ST_STROBE:
        if (beat_done)
          next_state = more_beats ? ext_bus_pkg::ST_LATCH
                                  : ext_bus_pkg::ST_IDLE;
      ext_bus_pkg::ST_HOLD:
        if (!hold_asked)
          next_state = ext_bus_pkg::ST_GAP;
      ext_bus_pkg::ST_GAP:
        next_state = ext_bus_pkg::ST_IDLE;
      default:
        next_state = ext_bus_pkg::ST_IDLE;
    endcase
  end

  // Strap is caught by a clocked process, not by the reset itself
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      strap_narrow <= ext_bus_pkg::STRAP_WIDE_16;
    else if (in_idle)
      strap_narrow <= pins.byte_strap;
  end

  // Sequencer state and the latched request
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state     <= ext_bus_pkg::ST_IDLE;
      is_write  <= 1'h0;
      narrow    <= 1'h0;
      phase     <= 1'h0;
      second    <= 1'h0;
      base_addr <= 24'h000000;
      wdata     <= 16'h0000;
      byte_en   <= 2'h0;
      sel_hit   <= 4'h0;
    end
    else
    begin
      state <= next_state;
      if (take_ext && !hold_asked)
      begin
        is_write  <= req_write;
        narrow    <= req_narrow;
        phase     <= req_narrow ? first_phase : 1'h0;
        second    <= both_bytes;
        base_addr <= req_addr;
        wdata     <= req_wdata;
        byte_en   <= req_byte_en;
        sel_hit   <= req_hits;
      end
      else if (beat_done && more_beats)
        phase <= 1'h1;
    end
  end

  // Core handshake and read data gathering
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      req_ready     <= 1'h0;
      resp_valid    <= 1'h0;
      resp_internal <= 1'h0;
      resp_rdata    <= 16'h0000;
    end
    else
    begin
      req_ready     <= take && !(take_ext && hold_asked);
      resp_valid    <= take_int || (beat_done && !more_beats);
      resp_internal <= take_int;
      if (take_int)
        resp_rdata <= 16'h0000;
      else if (beat_done && !is_write)
      begin
        if (!narrow)
          resp_rdata <= pins.data_level;
        else if (phase)
          resp_rdata[15:8] <= pins.data_level[7:0];
        else
          resp_rdata[7:0] <= pins.data_level[7:0];
      end
    end
  end

  // Pin registers; strobes and latch pulse follow the state
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      pins.read_strobe_n            <= 1'h1;
      pins.low_byte_write_strobe_n  <= 1'h1;
      pins.high_byte_write_strobe_n <= 1'h1;
      pins.ale                      <= 1'h0;
      pins.area_select_n            <= 4'hF;
      pins.addr                     <= 24'h000000;
      pins.addr_oe                  <= 1'h1;
      pins.ctrl_oe                  <= 1'h1;
      pins.dev_data                 <= 16'h0000;
      pins.dev_data_oe              <= 1'h0;
      pins.bus_grant_ack_n          <= 1'h1;
      bus_held                      <= 1'h0;
    end
    else
    begin
      // Latch pulse for one cycle, then strobes fall
      pins.ale <= (next_state == ext_bus_pkg::ST_LATCH);
      pins.read_strobe_n <= !((next_state == ext_bus_pkg::ST_STROBE) &&
                              !is_write);
      pins.low_byte_write_strobe_n <= !((next_state ==
                                         ext_bus_pkg::ST_STROBE) &&
                                        is_write && beat_low_wr);
      pins.high_byte_write_strobe_n <= !((next_state ==
                                          ext_bus_pkg::ST_STROBE) &&
                                         is_write && beat_high_wr);
      if (next_state == ext_bus_pkg::ST_LATCH ||
          next_state == ext_bus_pkg::ST_STROBE)
        pins.area_select_n <= ~latch_sel;
      else
        pins.area_select_n <= 4'hF;
      if (next_state == ext_bus_pkg::ST_LATCH)
        pins.addr <= latch_addr;
      pins.dev_data <= beat_wdata;
      pins.dev_data_oe <= is_write && (next_state ==
                                       ext_bus_pkg::ST_STROBE);
      // Acknowledge and floating share one edge
      pins.bus_grant_ack_n <= (next_state != ext_bus_pkg::ST_HOLD);
      pins.addr_oe <= (next_state != ext_bus_pkg::ST_HOLD);
      pins.ctrl_oe <= (next_state != ext_bus_pkg::ST_HOLD);
      bus_held <= (next_state == ext_bus_pkg::ST_HOLD);
    end
  end

  // A flip-flop cannot copy the clock at full rate, so it is a wire
  assign pins.clk_out = clk_sys;

endmodule

// ==== inc/ext_bus_pkg.sv ====
package ext_bus_pkg;

  // Pin widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_AREAS = 4;

  // Processor mode field codes
  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP = 2'h0,
    MODE_MEM_EXPAND  = 2'h1,
    MODE_MICRO       = 2'h2,
    MODE_UNUSED      = 2'h3
  } proc_mode_t;

  // Bus width strap levels
  localparam logic STRAP_WIDE_16 = 1'h0;
  localparam logic STRAP_NARROW_8 = 1'h1;

  // Internal address map: SFR and RAM below RAM_END, ROM in a window
  localparam logic [23:0] INT_RAM_END   = 24'h001000;
  localparam logic [23:0] INT_ROM_START = 24'h00C000;
  localparam logic [23:0] INT_ROM_END   = 24'h020000;

  // Cycles of idle bus after the grant is released before a new access
  localparam int GAP_CYCLES = 1;

  // Device bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_LATCH  = 3'h1,
    ST_STROBE = 3'h2,
    ST_HOLD   = 3'h3,
    ST_GAP    = 3'h4
  } bus_state_t;

endpackage

// ==== inc/ext_bus_if.sv ====
`timescale 1ns/1ps
interface ext_bus_if;
  // Device driven pins, all but clk_out and bus_grant_ack_n under an output enable
  logic        clk_out;
  logic [23:0] addr;
  logic        addr_oe;
  logic        read_strobe_n;
  logic        low_byte_write_strobe_n;
  logic        high_byte_write_strobe_n;
  logic        ale;
  logic [3:0]  area_select_n;
  logic        ctrl_oe;
  logic [15:0] dev_data;
  logic        dev_data_oe;
  logic        bus_grant_ack_n;
  // Far side driven pins
  logic [15:0] mem_data;
  logic        mem_data_oe;
  logic        ready;
  logic        hold_req_n;
  logic        byte_strap;
  // Resolved levels, pulled up when nobody drives, except the latch pulse, pulled low
  logic        rd_level_n;
  logic        lw_level_n;
  logic        hw_level_n;
  logic        ale_level;
  logic [3:0]  cs_level_n;
  logic [15:0] data_level;

  assign rd_level_n = ctrl_oe ? read_strobe_n : 1'h1;
  assign lw_level_n = ctrl_oe ? low_byte_write_strobe_n : 1'h1;
  assign hw_level_n = ctrl_oe ? high_byte_write_strobe_n : 1'h1;
  assign ale_level  = ctrl_oe ? ale : 1'h0;
  assign cs_level_n = ctrl_oe ? area_select_n : 4'hF;
  assign data_level = dev_data_oe ? dev_data :
                      (mem_data_oe ? mem_data : 16'hFFFF);

  modport device (
    output clk_out, addr, addr_oe, read_strobe_n, low_byte_write_strobe_n,
    output high_byte_write_strobe_n, ale, area_select_n, ctrl_oe,
    output dev_data, dev_data_oe, bus_grant_ack_n,
    input  data_level, ready, hold_req_n, byte_strap
  );

  modport far (
    input  clk_out, addr, addr_oe, rd_level_n, lw_level_n, hw_level_n,
    input  ale_level, cs_level_n, data_level, bus_grant_ack_n,
    output mem_data, mem_data_oe, ready, hold_req_n, byte_strap
  );
endinterface

// ==== hdl/ext_bus_far.sv ====
`timescale 1ns/1ps
module ext_bus_far #(
  parameter int MEM_BYTES   = 256,
  parameter int WAIT_CYCLES = 1,
  parameter bit NARROW_BUS  = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Bus master side
  input  wire logic master_req,
  output logic      master_granted,
  // Pins
  ext_bus_if.far    pins
);

  localparam int AW = $clog2(MEM_BYTES);

  logic [7:0]    mem [MEM_BYTES];
  logic [23:0]   latched_addr;
  logic [7:0]    wait_cnt;

  // Address seen by the memory: transparent while the pulse is high
  wire [23:0] cur_addr = pins.ale_level ? pins.addr : latched_addr;
  wire [AW-1:0] lo_idx = cur_addr[AW-1:0];
  wire [AW-1:0] hi_idx = cur_addr[AW-1:0] | AW'(1);
  wire strobe_low = !pins.rd_level_n || !pins.lw_level_n ||
                    !pins.hw_level_n;
  wire waited = (wait_cnt >= 8'(WAIT_CYCLES));

  // Address latch, wait counter and write port
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      latched_addr <= 24'h000000;
      wait_cnt     <= 8'h00;
    end
    else
    begin
      if (pins.ale_level)
        latched_addr <= pins.addr;
      wait_cnt <= strobe_low && !waited ? wait_cnt + 8'h01 :
                  (strobe_low ? wait_cnt : 8'h00);
      if (!pins.lw_level_n && waited)
        mem[lo_idx] <= pins.data_level[7:0];
      if (!pins.hw_level_n && waited)
        mem[hi_idx] <= pins.data_level[15:8];
    end
  end

  // Ready held low until the wait count runs out
  assign pins.ready = !strobe_low || waited;
  assign pins.mem_data = {mem[hi_idx], mem[lo_idx]};
  assign pins.mem_data_oe = !pins.rd_level_n;
  assign pins.byte_strap = NARROW_BUS ? ext_bus_pkg::STRAP_NARROW_8
                                      : ext_bus_pkg::STRAP_WIDE_16;

  // Hold request and grant report
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      pins.hold_req_n <= 1'h1;
      master_granted  <= 1'h0;
    end
    else
    begin
      pins.hold_req_n <= !master_req;
      master_granted  <= !pins.bus_grant_ack_n;
    end
  end

endmodule

// ==== tb/ext_bus_props.sv ====
`timescale 1ns/1ps
module ext_bus_props (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // Interface levels
  input wire logic       addr_oe,
  input wire logic       ctrl_oe,
  input wire logic       dev_data_oe,
  input wire logic       rd_level_n,
  input wire logic       lw_level_n,
  input wire logic       hw_level_n,
  input wire logic       ale_level,
  input wire logic [3:0] cs_level_n,
  input wire logic       bus_grant_ack_n,
  input wire logic       hold_req_n,
  input wire logic       ready
);
  // Any strobe low, so reads and writes share one timing check
  wire strobe_low = !rd_level_n || !lw_level_n || !hw_level_n;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Latch pulse is one cycle wide and opens the strobe phase
  sequence s_latch_strobe;
    ale_level ##1 (!ale_level && strobe_low);
  endsequence
  // Outside master needs a quiet bus right after the grant ends
  sequence s_quiet_gap;
    (!ale_level && !strobe_low) ##1 !ale_level;
  endsequence
  a_latch_then_strobe: assert property (ale_level |-> s_latch_strobe)
    else $error("latch pulse not followed by strobe");
  a_strobe_after_latch: assert property (
    $rose(strobe_low) |-> $past(ale_level))
    else $error("strobe fell without latch pulse");
  a_strobe_exclusive: assert property (
    !(!rd_level_n && (!lw_level_n || !hw_level_n)))
    else $error("read and write strobes low together");
  a_ready_stretch: assert property (strobe_low && !ready |=> strobe_low)
    else $error("strobe ended while not ready");
  a_grant_idle: assert property (
    $fell(bus_grant_ack_n) |-> !$past(strobe_low) && !$past(ale_level))
    else $error("grant given during an access");
  a_grant_bound: assert property (
    $fell(hold_req_n) |-> ##[1:20] !bus_grant_ack_n)
    else $error("hold request not granted in time");
  a_hold_float: assert property (
    !bus_grant_ack_n |-> !addr_oe && !ctrl_oe && !dev_data_oe)
    else $error("pins driven during hold");
  a_resume_drive: assert property (
    $rose(bus_grant_ack_n) |-> addr_oe && ctrl_oe)
    else $error("drive not resumed with acknowledge");
  a_release_gap: assert property (
    $rose(bus_grant_ack_n) |-> s_quiet_gap)
    else $error("access started too soon after hold");
  // Selects settle with the latch pulse, so they must not move as the
  // strobe falls
  a_select_steady: assert property (
    $rose(strobe_low) |-> $stable(cs_level_n))
    else $error("area select moved at strobe");
endmodule

// ==== tb/tb_external_bus_control.sv ====
`timescale 1ns/1ps
module tb_external_bus_control;
  // Bench state
  logic        clk_sys = 1'h0, reset_n = 1'h0;
  int          num_errors = 0, comparisons = 0;
  logic [31:0] seed = 32'h00000014, r;
  logic [1:0]  proc_mode = 2'h2;
  logic [23:0] area_first [4], area_last [4], req_addr = 24'h000000, a;
  logic [3:1]  area_narrow = 3'h2;
  logic        req_valid = 1'h0, req_write = 1'h0, master_req = 1'h0;
  logic [15:0] req_wdata = 16'h0000, resp_rdata, d, q;
  logic [1:0]  req_byte_en = 2'h3;
  logic        req_ready, resp_valid, resp_internal, bus_held;
  logic        master_granted, intl, prd = 1'h1, plw = 1'h1, phw = 1'h1;
  logic [7:0]  rd_falls = 8'h00, lw_falls = 8'h00, hw_falls = 8'h00;
  logic [3:0]  cs_seen = 4'hF;

  ext_bus_if bus ();
  ext_bus_device ext_bus_device_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .proc_mode(proc_mode), .area_first(area_first), .area_last(area_last),
    .area_narrow(area_narrow), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en),
    .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_internal(resp_internal), .resp_rdata(resp_rdata),
    .bus_held(bus_held), .pins(bus));
  ext_bus_far #(.MEM_BYTES(256), .WAIT_CYCLES(1), .NARROW_BUS(1'b0))
    ext_bus_far_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .master_req(master_req), .master_granted(master_granted), .pins(bus));
  ext_bus_props ext_bus_props_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .addr_oe(bus.addr_oe), .ctrl_oe(bus.ctrl_oe),
    .dev_data_oe(bus.dev_data_oe), .rd_level_n(bus.rd_level_n),
    .lw_level_n(bus.lw_level_n), .hw_level_n(bus.hw_level_n),
    .ale_level(bus.ale_level), .cs_level_n(bus.cs_level_n),
    .bus_grant_ack_n(bus.bus_grant_ack_n), .hold_req_n(bus.hold_req_n),
    .ready(bus.ready));

  always #2.5 clk_sys = ~clk_sys;

  // Four areas tile the map; the device decodes internal space first
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      area_first[i] = {2'(i), 22'h000000};
      area_last[i] = {2'(i), 22'h3FFFFF};
    end
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic int_exp(input logic [1:0] m, input logic [23:0] x);
    return m == 2'h0 || m == 2'h3 || x < ext_bus_pkg::INT_RAM_END ||
      (m == 2'h1 && x >= ext_bus_pkg::INT_ROM_START &&
       x < ext_bus_pkg::INT_ROM_END);
  endfunction
  // Low and high strobe falls for a two byte access
  function automatic logic [15:0] cnt_exp(input logic [23:0] x);
    return (x[23:22] != 2'h0 && area_narrow[x[23:22]]) ? 16'h0200 : 16'h0101;
  endfunction

  task automatic check1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Request held until taken; one idle edge keeps drivers apart
  task automatic xfer(input logic w, input logic [23:0] x,
                      input logic [15:0] v, output logic [15:0] rq,
                      output logic ri);
    int n;
    n = 0;
    req_write <= w;
    req_addr <= x;
    req_wdata <= v;
    req_valid <= 1'h1;
    do @(posedge clk_sys); while (req_ready !== 1'h1 && ++n < 200);
    req_valid <= 1'h0;
    while (resp_valid !== 1'h1 && ++n < 200) @(posedge clk_sys);
    if (n >= 200)
      num_errors++;
    rq = resp_rdata;
    ri = resp_internal;
    @(posedge clk_sys);
  endtask
  task automatic wait_grant(input logic lvl);
    int n;
    n = 0;
    while (master_granted !== lvl && ++n < 50) @(posedge clk_sys);
    check1(master_granted, lvl);
  endtask

  // Strobe edge counters and the select seen while strobing
  always @(posedge clk_sys)
  begin
    rd_falls += 8'(prd && !bus.rd_level_n);
    lw_falls += 8'(plw && !bus.lw_level_n);
    hw_falls += 8'(phw && !bus.hw_level_n);
    if (!bus.rd_level_n || !bus.lw_level_n)
      cs_seen = bus.cs_level_n;
    {prd, plw, phw} = {bus.rd_level_n, bus.lw_level_n, bus.hw_level_n};
  end

  // Bounded well above the longest expected run
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    stop_test();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk_sys);
    check16({7'h00, bus.rd_level_n, bus.lw_level_n, bus.hw_level_n,
      bus.ale_level, bus.bus_grant_ack_n, bus.cs_level_n}, 16'h01DF);
    #1;
    check1(bus.clk_out, 1'h1);
    @(posedge clk_sys);
    $display("test idle done");
    for (int i = 0; i < 12; i++)
    begin
      r = rnd();
      a = {r[1:0], 14'h0020, r[9:3], 1'h0};
      d = r[31:16];
      {lw_falls, hw_falls, rd_falls} = 24'h000000;
      xfer(1'h1, a, d, q, intl);
      check16({lw_falls, hw_falls}, cnt_exp(a));
      xfer(1'h0, a, 16'h0000, q, intl);
      check16(q, d);
      check16({8'h00, rd_falls}, cnt_exp(a) >> 8);
      check16({12'h000, cs_seen}, {12'h000, ~(4'h1 << a[23:22])});
    end
    $display("test access done");
    master_req <= 1'h1;
    wait_grant(1'h1);
    check16({12'h000, bus_held, bus.bus_grant_ack_n, bus.addr_oe,
      bus.ctrl_oe}, 16'h0008);
    xfer(1'h0, 24'h000100, 16'h0000, q, intl);
    check1(intl, 1'h1);
    rd_falls = 8'h00;
    fork
      xfer(1'h0, a, 16'h0000, q, intl);
      begin
        repeat (10) @(posedge clk_sys);
        check16({8'h00, rd_falls}, 16'h0000);
        master_req <= 1'h0;
      end
    join
    check16(q, d);
    fork
      xfer(1'h0, a, 16'h0000, q, intl);
      begin
        repeat (2) @(posedge clk_sys);
        master_req <= 1'h1;
      end
    join
    check16(q, d);
    wait_grant(1'h1);
    master_req <= 1'h0;
    wait_grant(1'h0);
    $display("test hold done");
    for (int k = 0; k < 12; k++)
    begin
      proc_mode <= 2'(k / 3);
      a = k % 3 == 0 ? 24'h000100 : (k % 3 == 1 ? 24'h00C000 : 24'h002000);
      xfer(1'h0, a, 16'h0000, q, intl);
      check1(intl, int_exp(2'(k / 3), a));
    end
    $display("test mode done");
    stop_test();
  end
endmodule
